// file: rtl/crmd_cfg.svh
// field positions, header layout and message codes for the descriptor framer
`ifndef CRMD_CFG_SVH
`define CRMD_CFG_SVH
// descriptor field positions
`define CRMD_D_SNOOP 15:0
`define CRMD_D_NOSNOOP 31:16
`define CRMD_D_OBFF 35:32
`define CRMD_D_DEST 15:0
`define CRMD_D_VDM 63:32
`define CRMD_D_ATS 63:0
`define CRMD_D_TYPE 78:75
`define CRMD_D_CODE 111:104
`define CRMD_D_ROUTE 114:112
`define CRMD_D_BITS 128
// bits owned by neighbouring blocks, always zero here
`define CRMD_D_ZHI 127:115
`define CRMD_D_ZMID 103:79
`define CRMD_D_ZLO 74:64
// received header layout, dword 0 holds format and type
`define CRMD_H_FMTDATA 30
`define CRMD_H_TYPE 28:24
`define CRMD_H_MSGHI 28:27
`define CRMD_H_ROUTE 26:24
`define CRMD_H_CODE 7:0
`define CRMD_H_HI 31:16
`define CRMD_H_LO 15:0
`define CRMD_H_OBFF 3:0
// header type values
`define CRMD_T_MEM 5'h00
`define CRMD_T_LOCK 5'h01
`define CRMD_T_IO 5'h02
`define CRMD_T_CFG0 5'h04
`define CRMD_T_CFG1 5'h05
`define CRMD_T_FADD 5'h0c
`define CRMD_T_SWAP 5'h0d
`define CRMD_T_CAS 5'h0e
`define CRMD_T_MSG 2'h2
// message codes and routing
`define CRMD_M_LTR 8'h10
`define CRMD_M_OBFF 8'h12
`define CRMD_M_VDM0 8'h7e
`define CRMD_M_VDM1 8'h7f
`define CRMD_M_ATS_INV 8'h01
`define CRMD_M_ATS_CPL 8'h02
`define CRMD_M_ATS_PRQ 8'h04
`define CRMD_M_ATS_PRG 8'h05
`define CRMD_R_BYID 3'h2
// flow control
`define CRMD_MARGIN 3
`define CRMD_FIFO_DEPTH 16
`endif

// file: rtl/crmd_pkg.sv
// types used by the descriptor framer; its fifo takes no types from here
`default_nettype none
package crmd_pkg;
   // request type codes carried in the descriptor
   typedef enum logic [3:0] {
      CRMD_MEM_RD = 4'b0000,
      CRMD_MEM_WR = 4'b0001,
      CRMD_IO_RD = 4'b0010,
      CRMD_IO_WR = 4'b0011,
      CRMD_FADD = 4'b0100,
      CRMD_SWAP = 4'b0101,
      CRMD_CAS = 4'b0110,
      CRMD_LOCK_RD = 4'b0111,
      CRMD_CFG0_RD = 4'b1000,
      CRMD_CFG1_RD = 4'b1001,
      CRMD_CFG0_WR = 4'b1010,
      CRMD_CFG1_WR = 4'b1011,
      CRMD_MSG = 4'b1100,
      CRMD_VDM = 4'b1101,
      CRMD_ATS = 4'b1110,
      CRMD_RSVD = 4'b1111
   } crmd_req_t;
   // decode result: deliver flag and type code
   typedef struct packed {
      logic ok;
      crmd_req_t code;
   } crmd_dec_t;
endpackage : crmd_pkg
`default_nettype wire

// file: rtl/crmd_fifo_if.sv
// interface between the framer stage and its descriptor fifo
`timescale 1ns/1ns
`default_nettype none
interface crmd_fifo_if #(parameter int WIDTH = 129, parameter int LW = 5);
   logic wr_valid; // stage holds a word
   logic wr_ready; // fifo has room
   logic [WIDTH-1:0] wr_data;
   logic rd_valid; // output register full
   logic rd_ready; // consumer takes it
   logic [WIDTH-1:0] rd_data;
   logic [LW-1:0] level; // words in memory
   modport fill(output wr_valid, wr_data, rd_ready, input wr_ready, rd_valid, rd_data, level);
   modport store(input wr_valid, wr_data, rd_ready, output wr_ready, rd_valid, rd_data, level);
endinterface : crmd_fifo_if
`default_nettype wire

// file: rtl/crmd_fifo.sv
// descriptor fifo with a registered read port
`timescale 1ns/1ns
`default_nettype none
module crmd_fifo #(
   parameter int WIDTH = 129,
   parameter int DEPTH = 16
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // both sides
   crmd_fifo_if.store f
);
   // depth must be a power of two, pointers wrap by overflow
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH]; // storage, no reset needed
   logic [AW-1:0] wp_q; // write pointer
   logic [AW-1:0] rp_q; // read pointer
   logic [AW:0] cnt_q; // words held in memory
   logic [WIDTH-1:0] out_q; // read data register
   logic out_vld_q; // read register full
   logic push;
   logic pop;
   // memory moves into the output register whenever it is free or drained
   assign push = f.wr_valid & f.wr_ready;
   assign pop = (cnt_q != '0) & (~out_vld_q | f.rd_ready);
   assign f.wr_ready = (cnt_q != FULL);
   assign f.rd_valid = out_vld_q;
   assign f.rd_data = out_q;
   assign f.level = cnt_q;
   // storage write
   always_ff @(posedge core_clk) begin
      if (push) begin
         mem_q[wp_q] <= f.wr_data;
      end
   end
   // pointers and fill count
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         wp_q <= '0;
         rp_q <= '0;
         cnt_q <= '0;
      end else begin
         if (push) wp_q <= wp_q + 1'b1;
         if (pop) rp_q <= rp_q + 1'b1;
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
   // output register
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         out_q <= '0;
         out_vld_q <= 1'b0;
      end else begin
         if (pop) out_q <= mem_q[rp_q];
         out_vld_q <= pop | (out_vld_q & ~f.rd_ready);
      end
   end
   // held word may not change while waiting
   chk_fifo_out_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
      out_vld_q && !f.rd_ready |=> out_vld_q && $stable(out_q))
      else $error("fifo output changed while stalled");
endmodule : crmd_fifo
`default_nettype wire

// file: rtl/crmd_framer.sv
// completer request descriptor framer: message fields and request type code
// How it works
// - ltr snoop latency into bits 15:0
// - ltr no-snoop latency into bits 31:16
// - flush code into bits 35:32
// - message code into bits 111:104
// - message routing into bits 114:112
// - vendor message by id: destination into 15:0
// - vendor message: header dword 3 into 63:32
// - translation message: dwords 2,3 into 63:0
// - memory, io and atomic type codes 0000-0110
// - locked read 0111, legacy devices only
// - configuration codes 1000-1011, never delivered here
// - message codes 1100-1110, 1111 reserved
// - type code sits in bits 78:75
// - descriptor and its payload flag leave together in the same cycle
`timescale 1ns/1ns
`default_nettype none
`include "crmd_cfg.svh"
module crmd_framer #(
   parameter int DEPTH = `CRMD_FIFO_DEPTH,
   parameter bit LEGACY = 1'b0
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // received header from the transaction layer
   input wire logic hdr_valid,
   output logic hdr_ready,
   input wire logic [31:0] hdr_dw0,
   input wire logic [31:0] hdr_dw1,
   input wire logic [31:0] hdr_dw2,
   input wire logic [31:0] hdr_dw3,
   output logic hdr_discard,
   // descriptor stream on the completer request path
   output logic desc_valid,
   input wire logic desc_ready,
   output logic [127:0] desc_data,
   output logic desc_payload
);
   localparam int W = `CRMD_D_BITS + 1; // descriptor plus payload flag
   localparam int LW = $clog2(DEPTH) + 1;

   // vendor-defined message codes
   function automatic logic is_vdm(input logic [7:0] mc);
      is_vdm = (mc == `CRMD_M_VDM0) || (mc == `CRMD_M_VDM1);
   endfunction : is_vdm

   // address translation message codes
   function automatic logic is_ats(input logic [7:0] mc);
      is_ats = (mc == `CRMD_M_ATS_INV) || (mc == `CRMD_M_ATS_CPL) ||
         (mc == `CRMD_M_ATS_PRQ) || (mc == `CRMD_M_ATS_PRG);
   endfunction : is_ats

   // header format and type to request type code
   function automatic crmd_pkg::crmd_dec_t decode(input logic [31:0] dw0,
      input logic [31:0] dw1);
      crmd_pkg::crmd_dec_t d;
      logic [4:0] t;
      logic wr;
      logic [7:0] mc;
      t = dw0[`CRMD_H_TYPE];
      wr = dw0[`CRMD_H_FMTDATA];
      mc = dw1[`CRMD_H_CODE];
      // default is deliverable; drops clear ok below
      d.ok = 1'b1;
      d.code = crmd_pkg::CRMD_RSVD;
      if (dw0[`CRMD_H_MSGHI] == `CRMD_T_MSG) begin
         // message group split by code
         if (is_vdm(mc)) begin
            d.code = crmd_pkg::CRMD_VDM;
         end else if (is_ats(mc)) begin
            d.code = crmd_pkg::CRMD_ATS;
         end else begin
            d.code = crmd_pkg::CRMD_MSG;
         end
      end else if (t == `CRMD_T_MEM) begin
         d.code = wr ? crmd_pkg::CRMD_MEM_WR : crmd_pkg::CRMD_MEM_RD;
      end else if (t == `CRMD_T_IO) begin
         d.code = wr ? crmd_pkg::CRMD_IO_WR : crmd_pkg::CRMD_IO_RD;
      end else if (t == `CRMD_T_FADD) begin
         d.code = crmd_pkg::CRMD_FADD;
      end else if (t == `CRMD_T_SWAP) begin
         d.code = crmd_pkg::CRMD_SWAP;
      end else if (t == `CRMD_T_CAS) begin
         d.code = crmd_pkg::CRMD_CAS;
      end else if (t == `CRMD_T_LOCK) begin
         // non-legacy completers never see locked reads
         d.code = crmd_pkg::CRMD_LOCK_RD;
         d.ok = LEGACY;
      end else if (t == `CRMD_T_CFG0) begin
         // configuration is served inside, not on this path
         d.code = wr ? crmd_pkg::CRMD_CFG0_WR : crmd_pkg::CRMD_CFG0_RD;
         d.ok = 1'b0;
      end else if (t == `CRMD_T_CFG1) begin
         d.code = wr ? crmd_pkg::CRMD_CFG1_WR : crmd_pkg::CRMD_CFG1_RD;
         d.ok = 1'b0;
      end else begin
         // unknown type, never framed with the reserved code
         d.ok = 1'b0;
      end
      decode = d;
   endfunction : decode

   // header plus type code to descriptor word
   function automatic logic [127:0] build(input logic [31:0] dw0,
      input logic [31:0] dw1, input logic [31:0] dw2, input logic [31:0] dw3,
      input crmd_pkg::crmd_req_t code);
      logic [127:0] d;
      logic [7:0] mc;
      logic [2:0] rt;
      // fields not defined for the type stay zero
      d = '0;
      mc = dw1[`CRMD_H_CODE];
      rt = dw0[`CRMD_H_ROUTE];
      d[`CRMD_D_TYPE] = code;
      // message fields only for the three message codes
      if (code == crmd_pkg::CRMD_MSG || code == crmd_pkg::CRMD_VDM ||
         code == crmd_pkg::CRMD_ATS) begin
         d[`CRMD_D_CODE] = mc;
         d[`CRMD_D_ROUTE] = rt;
         if (code == crmd_pkg::CRMD_MSG && mc == `CRMD_M_LTR) begin
            d[`CRMD_D_SNOOP] = dw3[`CRMD_H_LO];
            d[`CRMD_D_NOSNOOP] = dw3[`CRMD_H_HI];
         end else if (code == crmd_pkg::CRMD_MSG && mc == `CRMD_M_OBFF) begin
            // reserved flush codes pass through unchanged
            d[`CRMD_D_OBFF] = dw3[`CRMD_H_OBFF];
         end else if (code == crmd_pkg::CRMD_VDM) begin
            d[`CRMD_D_VDM] = dw3;
            if (rt == `CRMD_R_BYID) begin
               d[`CRMD_D_DEST] = dw2[`CRMD_H_HI];
            end
         end else if (code == crmd_pkg::CRMD_ATS) begin
            d[`CRMD_D_ATS] = {dw3, dw2};
         end
      end
      build = d;
   endfunction : build

   crmd_pkg::crmd_dec_t dec; // decode of the offered header
   logic accept; // header taken this cycle
   logic hdr_ready_q; // registered ready toward the source
   logic discard_q; // one-cycle pulse for a dropped header
   logic s_vld_q; // stage holds a descriptor
   logic [W-1:0] s_q; // stage word, payload flag on top

   crmd_fifo_if #(.WIDTH(W), .LW(LW)) fif ();

   // decode runs on the header as offered
   always_comb begin
      dec = decode(hdr_dw0, hdr_dw1);
   end

   // a header moves only on valid and registered ready
   assign accept = hdr_valid & hdr_ready_q;

   // ready is registered, so it lags the fifo by one cycle;
   // the margin covers the stage word and one header in flight
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         hdr_ready_q <= 1'b0;
      end else begin
         hdr_ready_q <= (int'(fif.level) + `CRMD_MARGIN <= DEPTH);
      end
   end

   // stage valid: loaded by a delivered header, emptied into the fifo
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         s_vld_q <= 1'b0;
      end else if (accept && dec.ok) begin
         s_vld_q <= 1'b1;
      end else if (fif.wr_ready) begin
         s_vld_q <= 1'b0;
      end
   end

   // stage data: descriptor with payload flag above it
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         s_q <= '0;
      end else if (accept && dec.ok) begin
         s_q <= {hdr_dw0[`CRMD_H_FMTDATA],
            build(hdr_dw0, hdr_dw1, hdr_dw2, hdr_dw3, dec.code)};
      end
   end

   // dropped headers still leave the source, flagged by a pulse
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         discard_q <= 1'b0;
      end else begin
         discard_q <= accept & ~dec.ok;
      end
   end

   // descriptor buffer, drained by the user side
   crmd_fifo #(.WIDTH(W), .DEPTH(DEPTH)) u_fifo (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .f(fif.store)
   );

   // stage feeds the fifo; the margin keeps wr_ready high here
   assign fif.wr_valid = s_vld_q;
   assign fif.wr_data = s_q;
   assign fif.rd_ready = desc_ready;

   // outputs come from the fifo output register and local flops
   assign hdr_ready = hdr_ready_q;
   assign hdr_discard = discard_q;
   assign desc_valid = fif.rd_valid;
   assign desc_data = fif.rd_data[`CRMD_D_BITS-1:0];
   assign desc_payload = fif.rd_data[`CRMD_D_BITS];

   // helpers for checks on the stage word
   // acc_msg looks at the raw header, not at the decode
   logic acc_msg;
   logic [7:0] in_code;
   assign acc_msg = accept && (hdr_dw0[`CRMD_H_MSGHI] == `CRMD_T_MSG);
   assign in_code = hdr_dw1[`CRMD_H_CODE];

   chk_ltr_snoop_val: assert property (@(posedge core_clk) disable iff (!rst_n)
      acc_msg && in_code == `CRMD_M_LTR |=>
      s_vld_q && s_q[`CRMD_D_SNOOP] == $past(hdr_dw3[`CRMD_H_LO]))
      else $error("snoop latency not framed");

   chk_ltr_nosnoop_val: assert property (@(posedge core_clk) disable iff (!rst_n)
      acc_msg && in_code == `CRMD_M_LTR |=>
      s_q[`CRMD_D_NOSNOOP] == $past(hdr_dw3[`CRMD_H_HI]))
      else $error("no-snoop latency not framed");

   chk_obff_code_val: assert property (@(posedge core_clk) disable iff (!rst_n)
      acc_msg && in_code == `CRMD_M_OBFF |=>
      s_q[`CRMD_D_OBFF] == $past(hdr_dw3[`CRMD_H_OBFF]) &&
      s_q[`CRMD_D_NOSNOOP] == '0 && s_q[`CRMD_D_SNOOP] == '0)
      else $error("flush code not framed");

   chk_msg_code_route: assert property (@(posedge core_clk) disable iff (!rst_n)
      acc_msg |=> s_q[`CRMD_D_CODE] == $past(in_code) &&
      s_q[`CRMD_D_ROUTE] == $past(hdr_dw0[`CRMD_H_ROUTE]))
      else $error("message code or routing wrong");

   chk_vdm_dest_hdr: assert property (@(posedge core_clk) disable iff (!rst_n)
      acc_msg && is_vdm(in_code) && hdr_dw0[`CRMD_H_ROUTE] == `CRMD_R_BYID |=>
      s_q[`CRMD_D_DEST] == $past(hdr_dw2[`CRMD_H_HI]) &&
      s_q[`CRMD_D_VDM] == $past(hdr_dw3))
      else $error("vendor message fields wrong");

   chk_ats_header_copy: assert property (@(posedge core_clk) disable iff (!rst_n)
      acc_msg && is_ats(in_code) |=> s_q[`CRMD_D_ATS] == $past({hdr_dw3, hdr_dw2}) &&
      s_q[`CRMD_D_TYPE] == crmd_pkg::CRMD_ATS)
      else $error("translation header wrong");

   chk_mem_type_code: assert property (@(posedge core_clk) disable iff (!rst_n)
      accept && hdr_dw0[`CRMD_H_TYPE] == `CRMD_T_MEM |=>
      s_q[`CRMD_D_TYPE] == {3'h0, $past(hdr_dw0[`CRMD_H_FMTDATA])} &&
      s_q[`CRMD_D_ATS] == '0 && s_q[`CRMD_D_ROUTE] == '0 && s_q[`CRMD_D_CODE] == '0)
      else $error("memory request type wrong");

   chk_cfg_lock_drop: assert property (@(posedge core_clk) disable iff (!rst_n)
      accept && (hdr_dw0[`CRMD_H_TYPE] == `CRMD_T_CFG0 ||
      (!LEGACY && hdr_dw0[`CRMD_H_TYPE] == `CRMD_T_LOCK)) |=>
      hdr_discard && $stable(s_q))
      else $error("configuration or locked request framed");

   // reserved 1111 sits inside the message range, so the or needs its brackets
   chk_no_rsvd_code: assert property (@(posedge core_clk) disable iff (!rst_n)
      desc_valid |-> desc_data[`CRMD_D_TYPE] != crmd_pkg::CRMD_RSVD &&
      (desc_data[`CRMD_D_TYPE] < crmd_pkg::CRMD_CFG0_RD ||
      desc_data[`CRMD_D_TYPE] >= crmd_pkg::CRMD_MSG))
      else $error("illegal type code delivered");

   chk_payload_flag: assert property (@(posedge core_clk) disable iff (!rst_n)
      accept && dec.ok |=> s_q[`CRMD_D_BITS] == $past(hdr_dw0[`CRMD_H_FMTDATA]))
      else $error("payload flag wrong");

   chk_stage_no_block: assert property (@(posedge core_clk) disable iff (!rst_n)
      s_vld_q |-> fif.wr_ready)
      else $error("stage blocked by full fifo");

   // io requests split on the data bit
   chk_io_type_code: assert property (@(posedge core_clk) disable iff (!rst_n)
      accept && hdr_dw0[`CRMD_H_TYPE] == `CRMD_T_IO |=> s_vld_q &&
      s_q[`CRMD_D_TYPE] == ($past(hdr_dw0[`CRMD_H_FMTDATA]) ?
      crmd_pkg::CRMD_IO_WR : crmd_pkg::CRMD_IO_RD))
      else $error("io request type wrong");

   // atomics carry fixed codes whatever the data bit says
   chk_fadd_type_code: assert property (@(posedge core_clk) disable iff (!rst_n)
      accept && hdr_dw0[`CRMD_H_TYPE] == `CRMD_T_FADD |=>
      s_vld_q && s_q[`CRMD_D_TYPE] == crmd_pkg::CRMD_FADD)
      else $error("fetch-and-add type wrong");

   chk_swap_type_code: assert property (@(posedge core_clk) disable iff (!rst_n)
      accept && hdr_dw0[`CRMD_H_TYPE] == `CRMD_T_SWAP |=>
      s_vld_q && s_q[`CRMD_D_TYPE] == crmd_pkg::CRMD_SWAP)
      else $error("swap type wrong");

   chk_cas_type_code: assert property (@(posedge core_clk) disable iff (!rst_n)
      accept && hdr_dw0[`CRMD_H_TYPE] == `CRMD_T_CAS |=>
      s_vld_q && s_q[`CRMD_D_TYPE] == crmd_pkg::CRMD_CAS)
      else $error("compare-and-swap type wrong");

   // a legacy build hands locked reads on like any read
   chk_lock_legacy_code: assert property (@(posedge core_clk) disable iff (!rst_n)
      accept && LEGACY && hdr_dw0[`CRMD_H_TYPE] == `CRMD_T_LOCK |=>
      s_vld_q && !hdr_discard && s_q[`CRMD_D_TYPE] == crmd_pkg::CRMD_LOCK_RD)
      else $error("locked read not framed");

   // type 1 configuration is dropped too, the stage stays empty
   chk_cfg1_type_drop: assert property (@(posedge core_clk) disable iff (!rst_n)
      accept && hdr_dw0[`CRMD_H_TYPE] == `CRMD_T_CFG1 |=> hdr_discard && !s_vld_q)
      else $error("type 1 configuration framed");

   // plain messages: neither vendor nor translation codes
   chk_msg_type_code: assert property (@(posedge core_clk) disable iff (!rst_n)
      acc_msg && !is_vdm(in_code) && !is_ats(in_code) |=>
      s_vld_q && s_q[`CRMD_D_TYPE] == crmd_pkg::CRMD_MSG)
      else $error("message type wrong");

   // vendor message not routed by id leaves the destination clear
   chk_vdm_other_route: assert property (@(posedge core_clk) disable iff (!rst_n)
      acc_msg && is_vdm(in_code) && hdr_dw0[`CRMD_H_ROUTE] != `CRMD_R_BYID |=>
      s_q[`CRMD_D_DEST] == '0 && s_q[`CRMD_D_VDM] == $past(hdr_dw3) &&
      s_q[`CRMD_D_TYPE] == crmd_pkg::CRMD_VDM)
      else $error("vendor message by route wrong");

   // bits that neighbouring blocks fill never leave nonzero from here
   chk_unused_bits_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
      desc_valid |-> desc_data[`CRMD_D_ZHI] == '0 && desc_data[`CRMD_D_ZMID] == '0 &&
      desc_data[`CRMD_D_ZLO] == '0)
      else $error("unowned descriptor bits set");

   // a stalled descriptor and its payload flag hold still
   chk_desc_stall_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
      desc_valid && !desc_ready |=> desc_valid && $stable(desc_data) &&
      $stable(desc_payload))
      else $error("descriptor changed while stalled");

   // ready drops one cycle after the fifo passes the margin
   chk_ready_refuse: assert property (@(posedge core_clk) disable iff (!rst_n)
      fif.level > DEPTH - `CRMD_MARGIN |=> !hdr_ready)
      else $error("header ready above the margin");

endmodule : crmd_framer
`default_nettype wire

// file: sim/crmd_sink.sv
// consumer model that takes descriptors off the completer request path
`timescale 1ns/1ns
`default_nettype none
module crmd_sink (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // back-pressure: 0 ready, 1 stalled, 2 pseudo-random
   input wire logic [1:0] mode,
   // descriptor stream
   input wire logic desc_valid,
   output logic desc_ready,
   input wire logic [127:0] desc_data,
   // protocol fault seen this cycle
   output logic bad
);
   logic [7:0] lfsr_q; // stall pattern, no random calls here
   logic held_q; // offered last cycle and not taken
   logic [127:0] last_q; // word offered last cycle
   initial desc_ready = 1'b0;
   // ready moves off the sampling edge only
   always @(negedge core_clk) begin
      lfsr_q <= rst_n ? {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]} : 8'h5a;
      desc_ready <= rst_n && (mode == 2'h0 || (mode == 2'h2 && lfsr_q[0]));
   end
   // a stalled word must stay put; config and reserved codes never arrive
   always @(posedge core_clk) begin
      bad <= 1'b0;
      held_q <= rst_n && desc_valid && !desc_ready;
      last_q <= desc_data;
      if (held_q && (desc_valid !== 1'b1 || desc_data !== last_q)) begin
         bad <= 1'b1;
      end
      if (desc_valid && desc_ready && (desc_data[78:77] === 2'h2 || desc_data[78:75] === 4'hf)) begin
         bad <= 1'b1;
      end
   end
endmodule : crmd_sink
`default_nettype wire

// file: sim/crmd_framer_test.sv
// self-checking bench for the descriptor framer
`timescale 1ns/1ns
`default_nettype none
module crmd_framer_test;
   localparam int DEPTH = 4; // shrunk so the fifo fills quickly
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic hdr_valid = 1'b0;
   logic [31:0] dw [4] = '{default: 32'h0};
   logic hdr_ready, hdr_discard, desc_valid, desc_ready, desc_payload, bad;
   logic [127:0] desc_data;
   logic [1:0] mode = 2'h0; // consumer back-pressure
   logic [129:0] e; // {deliver, payload, descriptor}
   logic [129:0] exp_q [$]; // words still owed
   int seed = 75348;
   int error_cnt = 0;
   int n_checks = 0;
   int taken = 0; // headers accepted
   int drops = 0; // headers that must be dropped
   int disc = 0; // discard pulses seen
   int k;
   logic [7:0] msg_tab [9] = '{8'h10, 8'h12, 8'h7e, 8'h7f, 8'h01, 8'h02, 8'h04, 8'h05, 8'h20};
   logic [4:0] typ_tab [10] = '{5'h00, 5'h01, 5'h02, 5'h04, 5'h05, 5'h0c, 5'h0d, 5'h0e, 5'h10, 5'h03};
   always #10 core_clk = ~core_clk;
   crmd_framer #(.DEPTH(DEPTH), .LEGACY(1'b1)) u_crmd_framer (
      .core_clk(core_clk), .rst_n(rst_n), .hdr_valid(hdr_valid), .hdr_ready(hdr_ready),
      .hdr_dw0(dw[0]), .hdr_dw1(dw[1]), .hdr_dw2(dw[2]), .hdr_dw3(dw[3]),
      .hdr_discard(hdr_discard), .desc_valid(desc_valid), .desc_ready(desc_ready),
      .desc_data(desc_data), .desc_payload(desc_payload));
   crmd_sink u_crmd_sink (.core_clk(core_clk), .rst_n(rst_n), .mode(mode),
      .desc_valid(desc_valid), .desc_ready(desc_ready), .desc_data(desc_data), .bad(bad));
   // expected descriptor from a header
   function automatic logic [129:0] exp_f(input logic [31:0] d0, d1, d2, d3);
      logic [127:0] d;
      logic ok;
      logic [7:0] m;
      d = '0;
      ok = 1'b1;
      m = d1[7:0];
      case (d0[28:24])
         5'h00: d[78:75] = {3'h0, d0[30]};
         5'h01: d[78:75] = 4'h7;
         5'h02: d[78:75] = {3'h1, d0[30]};
         5'h0c: d[78:75] = 4'h4;
         5'h0d: d[78:75] = 4'h5;
         5'h0e: d[78:75] = 4'h6;
         default: ok = 1'b0;
      endcase
      if (d0[28:27] == 2'h2) begin
         ok = 1'b1;
         d[111:104] = m;
         d[114:112] = d0[26:24];
         d[78:75] = 4'hc;
         if (m == 8'h10) d[31:0] = d3;
         if (m == 8'h12) d[35:32] = d3[3:0];
         if (m inside {8'h7e, 8'h7f}) begin
            d[78:75] = 4'hd;
            d[63:32] = d3;
            if (d0[26:24] == 3'h2) d[15:0] = d2[31:16];
         end
         if (m inside {8'h01, 8'h02, 8'h04, 8'h05}) begin
            d[78:75] = 4'he;
            d[63:0] = {d3, d2};
         end
      end
      return {ok, d0[30], d};
   endfunction : exp_f
   // count and report one comparison
   task automatic check(input logic ok, input string msg);
      n_checks++;
      if (!ok) begin
         error_cnt++;
         $display("wrong value at %0t: %s", $time, msg);
      end
   endtask : check
   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : stop_test
   // scoreboard: headers in, descriptors out
   always @(posedge core_clk) begin
      if (hdr_valid && hdr_ready === 1'b1) begin
         taken++;
         e = exp_f(dw[0], dw[1], dw[2], dw[3]);
         if (e[129]) exp_q.push_back(e);
         else drops++;
      end
      if (hdr_discard === 1'b1) disc++;
      if (bad === 1'b1) check(1'b0, "consumer saw a bad word");
      if (desc_valid === 1'b1 && desc_ready === 1'b1) begin
         if (exp_q.size() == 0) check(1'b0, "descriptor without header");
         else begin
            e = exp_q.pop_front();
            check(desc_data === e[127:0], "descriptor fields");
            check(desc_payload === e[128], "payload flag");
         end
      end
   end
   // offer one header, held until taken
   task automatic send(input logic [31:0] d0, d1, d2, d3);
      int n;
      n = 0;
      @(negedge core_clk);
      hdr_valid = 1'b1;
      dw = '{d0, d1, d2, d3};
      while (hdr_ready !== 1'b1 && n < 500) begin
         @(negedge core_clk);
         n++;
      end
      if (n >= 500) check(1'b0, "header never taken");
      @(posedge core_clk);
   endtask : send
   // header of a given type, data flag and message code, rest random
   task automatic hdr(input logic [4:0] t, input logic wr, input logic [7:0] m);
      logic [31:0] d0, d1;
      d0 = $random(seed);
      d1 = $random(seed);
      d0[31:24] = {1'b0, wr, d0[29], t};
      d1[7:0] = m;
      send(d0, d1, $random(seed), $random(seed));
   endtask : hdr
   // wait until every owed word has left
   task automatic drain();
      k = 0;
      while (exp_q.size() != 0 && k < 400) begin
         @(negedge core_clk);
         k++;
      end
      check(exp_q.size() == 0, "words lost");
   endtask : drain
   // the long wait outlasts the expected run many times over
   initial begin
      #(20 * 60000);
      check(1'b0, "watchdog expired");
      stop_test();
   end
   initial begin
      repeat (2) @(negedge core_clk);
      rst_n = 1'b1;
      // every type with and without data, then every message kind on every route
      for (int i = 0; i < 10; i++) begin
         hdr(typ_tab[i], 1'b0, 8'h10);
         hdr(typ_tab[i], 1'b1, 8'h7f);
      end
      for (int i = 0; i < 72; i++) hdr({2'h2, i[2:0]}, i[3], msg_tab[i / 8]);
      for (int i = 0; i < 16; i++) send({8'h14, 24'h0}, 32'h12, 32'h0, {28'h0, 4'(i)});
      @(negedge core_clk);
      hdr_valid = 1'b0;
      drain();
      $display("test corner done");
      // random traffic under random stalls
      mode = 2'h2;
      for (int i = 0; i < 300; i++) begin
         k = $unsigned($random(seed)) % 10;
         hdr(typ_tab[k] | (k == 8 ? 5'($random(seed) & 7) : 5'h0), k inside {5, 6, 7} ||
            $random(seed) % 2 == 0, msg_tab[$unsigned($random(seed)) % 9]);
      end
      @(negedge core_clk);
      hdr_valid = 1'b0;
      mode = 2'h0;
      drain();
      $display("test random done");
      // fill against a stalled consumer until headers are refused
      mode = 2'h1;
      k = taken;
      @(negedge core_clk);
      hdr_valid = 1'b1;
      dw = '{32'h0, 32'h0, 32'h0, 32'h0};
      repeat (DEPTH + 12) @(negedge core_clk);
      hdr_valid = 1'b0;
      check(hdr_ready === 1'b0, "full fifo still ready");
      check(taken - k >= DEPTH - 2 && taken - k <= DEPTH + 3, "fill count");
      mode = 2'h0;
      drain();
      repeat (4) @(negedge core_clk);
      check(disc == drops, "discard pulses");
      $display("test fill done");
      stop_test();
   end
endmodule : crmd_framer_test
`default_nettype wire
